// ### design/amid_pkg.sv
package amid_pkg;
    // Data-space homes of the two pointer registers
    localparam logic [7:0] PTR_X_ADDR = 8'h80;
    localparam logic [7:0] PTR_Y_ADDR = 8'h81;
    localparam int PTR_SEL_BIT = 4;
    // Base of the four short-direct locations
    localparam logic [7:0] SHORT_BASE = 8'h80;
    // Instruction-set size figures
    localparam int NUM_BASIC_OPS = 42;
    localparam int NUM_VALID_OPS = 242;
    // Inherent slots A0-A7 (bits 0-7) and B0-B7 (bits 8-15) that decode as valid
    localparam logic [15:0] INH_VALID_MASK = 16'h0307;
    // Byte lengths
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    // Reset values of the decode outputs
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_LEN = 2'h0;

    typedef enum logic [2:0] {
        AMID_CLS_REGMEM, AMID_CLS_RMW, AMID_CLS_BRANCH, AMID_CLS_BITMAN, AMID_CLS_CONTROL
    } amid_class_e;

    typedef enum logic [3:0] {
        AMID_MODE_IMM, AMID_MODE_DIRECT, AMID_MODE_SHORT, AMID_MODE_EXT, AMID_MODE_REL,
        AMID_MODE_BITSC, AMID_MODE_BITTB, AMID_MODE_INDIRECT, AMID_MODE_INHERENT
    } amid_mode_e;

    typedef enum logic [2:0] {
        AMID_MOD_NONE, AMID_MOD_ADD_ONE, AMID_MOD_SUBTRACT_ONE, AMID_MOD_SET,
        AMID_MOD_CLEAR, AMID_MOD_TEST
    } amid_mod_e;

    typedef enum logic [2:0] {
        AMID_ST_IDLE, AMID_ST_PTR, AMID_ST_READ, AMID_ST_MODIFY, AMID_ST_DONE
    } amid_state_e;
endpackage

// ### design/amid_classify.sv
`timescale 1ns/1ps
module amid_classify
    import amid_pkg::*;
(
    input wire logic [7:0] op,
    output amid_pkg::amid_class_e cls,
    output amid_pkg::amid_mode_e mode,
    output amid_pkg::amid_mod_e modk,
    output logic [1:0] len,
    output logic valid,
    output logic uses_acc
);
    // Pure opcode map; the caller registers everything
    always_comb
    begin
        cls = AMID_CLS_CONTROL;
        mode = AMID_MODE_INHERENT;
        modk = AMID_MOD_NONE;
        len = LEN_ONE;
        valid = 1'b1;
        uses_acc = 1'b0;
        if (op[7] == 1'b0)
        begin
            cls = AMID_CLS_BRANCH;
            mode = AMID_MODE_REL;
        end
        else if (op[7:5] == 3'b100)
        begin
            // call_op 80-8F, goto_op 90-9F: no register operand
            cls = AMID_CLS_REGMEM;
            mode = AMID_MODE_EXT;
            len = LEN_TWO;
            uses_acc = 1'b0;
        end
        else if (op[7:5] == 3'b101)
        begin
            if (op[3] == 1'b1)
            begin
                mode = AMID_MODE_SHORT;
                if (op[2] == 1'b0)
                begin
                    cls = AMID_CLS_RMW;
                    modk = op[4] ? AMID_MOD_SUBTRACT_ONE : AMID_MOD_ADD_ONE;
                end
                else
                begin
                    cls = AMID_CLS_REGMEM;
                    uses_acc = 1'b1;
                end
            end
            else
            begin
                // Inherent: all it needs is in the opcode itself
                valid = INH_VALID_MASK[{op[4], op[2:0]}];
            end
        end
        else if (op[7:5] == 3'b110)
        begin
            cls = AMID_CLS_BITMAN;
            if (op[4] == 1'b0)
            begin
                mode = AMID_MODE_BITTB;
                modk = AMID_MOD_TEST;
                len = LEN_THREE;
            end
            else
            begin
                mode = AMID_MODE_BITSC;
                modk = op[3] ? AMID_MOD_SET : AMID_MOD_CLEAR;
                len = LEN_TWO;
            end
        end
        else
        begin
            // E0-FF: indirect, immediate, direct by bit 3 and bit 4
            mode = (op[3] == 1'b0) ? AMID_MODE_INDIRECT :
                (op[4] ? AMID_MODE_DIRECT : AMID_MODE_IMM);
            len = (op[3] == 1'b0) ? LEN_ONE : LEN_TWO;
            if (op[2:1] == 2'b11)
            begin
                cls = AMID_CLS_RMW;
                modk = op[0] ? AMID_MOD_SUBTRACT_ONE : AMID_MOD_ADD_ONE;
                valid = (mode != AMID_MODE_IMM);
            end
            else
            begin
                cls = AMID_CLS_REGMEM;
                uses_acc = 1'b1;
                valid = !(mode == AMID_MODE_IMM && op[2:0] == 3'h1);
            end
        end
    end
endmodule

// ### design/amid_decoder.sv
`timescale 1ns/1ps
// What this block does
// - Register-indirect ops reach their operand at the address held in a pointer register.
// - Opcode bit 4 picks the first or the second pointer register.
// - Bit 4 clear maps to data address 80h, bit 4 set to 81h.
// - A register-indirect instruction is one program byte with no operand bytes.
// - Inherent ops use only the opcode and are one program byte.
// - There are 42 basic operations giving 242 valid opcodes over nine modes.
// - Every valid opcode falls in one of five classes.
// - Register/memory ops mostly pair the accumulator with a memory operand.
// - The goto and call operations take no register operand.
// - Read-modify-write reads the target, modifies or tests it, then writes it back.
// - All add-one, subtract-one and bit manipulation ops use the read-modify-write cycle.
// - A branch changes flow only when its condition holds.
// - Bit manipulation reaches any data bit: set/clear, and test with branch.
// - The pointer registers live at 80h and 81h as ordinary data memory.
module amid_decoder
    import amid_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic [7:0] op_arg,
    input wire logic flag_carry,
    input wire logic flag_zero,
    input wire logic [7:0] ds_rdata,
    output logic op_ready,
    output logic dec_valid,
    output logic dec_illegal,
    output amid_pkg::amid_class_e dec_class,
    output amid_pkg::amid_mode_e dec_mode,
    output logic [1:0] dec_len,
    output logic dec_uses_acc,
    output logic branch_taken,
    output logic [7:0] ds_addr,
    output logic ds_rd,
    output logic ds_wr,
    output logic [7:0] ds_wdata,
    output logic rmw_done
);
    import amid_pkg::*;

    amid_class_e c_cls;
    amid_mode_e c_mode;
    amid_mod_e c_modk;
    logic [1:0] c_len;
    logic c_valid;
    logic c_acc;

    amid_classify u_classify (
        .op(op_byte),
        .cls(c_cls),
        .mode(c_mode),
        .modk(c_modk),
        .len(c_len),
        .valid(c_valid),
        .uses_acc(c_acc)
    );

    amid_state_e state, next_state;
    amid_mod_e modk, next_modk;
    logic [2:0] bitn, next_bitn;
    logic [7:0] op_q, next_op_q;
    logic ptr_wait, next_ptr_wait;
    logic next_op_ready, next_dec_valid, next_dec_illegal, next_dec_uses_acc;
    logic next_branch_taken, next_ds_rd, next_ds_wr, next_rmw_done;
    amid_class_e next_dec_class;
    amid_mode_e next_dec_mode;
    logic [1:0] next_dec_len;
    logic [7:0] next_ds_addr, next_ds_wdata;
    logic start, cond_ok, needs_rmw;

    // Branch condition: bit 6 picks carry or zero, bit 5 the wanted level
    assign cond_ok = ((op_byte[6] ? flag_carry : flag_zero) == op_byte[5]);
    assign start = op_valid && op_ready;
    assign needs_rmw = c_valid && (c_cls == AMID_CLS_RMW || c_cls == AMID_CLS_BITMAN);

    // Next values of decode outputs and the read-modify-write sequencer
    always_comb
    begin
        next_state = state;
        next_modk = modk;
        next_bitn = bitn;
        next_op_q = op_q;
        next_ptr_wait = ptr_wait;
        next_op_ready = op_ready;
        next_dec_valid = 1'b0;
        next_dec_illegal = 1'b0;
        next_dec_class = dec_class;
        next_dec_mode = dec_mode;
        next_dec_len = dec_len;
        next_dec_uses_acc = dec_uses_acc;
        next_branch_taken = 1'b0;
        next_ds_rd = 1'b0;
        next_ds_wr = 1'b0;
        next_ds_addr = ds_addr;
        next_ds_wdata = ds_wdata;
        next_rmw_done = 1'b0;
        case (state)
            AMID_ST_IDLE:
            begin
                if (start)
                begin
                    next_dec_valid = c_valid;
                    next_dec_illegal = !c_valid;
                    next_dec_class = c_cls;
                    next_dec_mode = c_mode;
                    next_dec_len = c_len;
                    next_dec_uses_acc = c_acc;
                    next_branch_taken = c_valid && c_cls == AMID_CLS_BRANCH && cond_ok;
                    next_op_q = op_byte;
                    next_modk = c_modk;
                    next_bitn = op_byte[2:0];
                    if (needs_rmw)
                    begin
                        next_op_ready = 1'b0;
                        next_ds_rd = 1'b1;
                        if (c_mode == AMID_MODE_INDIRECT)
                        begin
                            // Fetch the pointer first; the opcode names it by bit 4
                            next_ds_addr = op_byte[PTR_SEL_BIT] ? PTR_Y_ADDR : PTR_X_ADDR;
                            next_state = AMID_ST_PTR;
                        end
                        else
                        begin
                            next_ds_addr = (c_mode == AMID_MODE_SHORT) ?
                                (SHORT_BASE | {6'h00, op_byte[1:0]}) : op_arg;
                            next_state = AMID_ST_READ;
                        end
                    end
                end
            end
            AMID_ST_PTR:
            begin
                // Pointer byte arrives a cycle after its read, so wait once, then follow it
                if (ptr_wait)
                begin
                    next_ptr_wait = 1'b0;
                    next_ds_addr = ds_rdata;
                    next_ds_rd = 1'b1;
                    next_state = AMID_ST_READ;
                end
                else
                begin
                    next_ptr_wait = 1'b1;
                end
            end
            AMID_ST_READ:
            begin
                next_state = AMID_ST_MODIFY;
            end
            AMID_ST_MODIFY:
            begin
                // Write back to the very address read; a test writes the value unchanged
                next_ds_wr = 1'b1;
                case (modk)
                    AMID_MOD_ADD_ONE: next_ds_wdata = ds_rdata + 8'h01;
                    AMID_MOD_SUBTRACT_ONE: next_ds_wdata = ds_rdata - 8'h01;
                    AMID_MOD_SET: next_ds_wdata = ds_rdata | (8'h01 << bitn);
                    AMID_MOD_CLEAR: next_ds_wdata = ds_rdata & ~(8'h01 << bitn);
                    default: next_ds_wdata = ds_rdata;
                endcase
                next_branch_taken = (modk == AMID_MOD_TEST) && (ds_rdata[bitn] == op_q[3]);
                next_state = AMID_ST_DONE;
            end
            AMID_ST_DONE:
            begin
                next_rmw_done = 1'b1;
                next_op_ready = 1'b1;
                next_state = AMID_ST_IDLE;
            end
            default:
            begin
                next_state = AMID_ST_IDLE;
                next_op_ready = 1'b1;
            end
        endcase
    end

    // Registered state; clock enable low holds everything
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= AMID_ST_IDLE;
            modk <= AMID_MOD_NONE;
            bitn <= 3'h0;
            op_q <= RST_BYTE;
            ptr_wait <= 1'b0;
            op_ready <= 1'b1;
            dec_valid <= 1'b0;
            dec_illegal <= 1'b0;
            dec_class <= AMID_CLS_CONTROL;
            dec_mode <= AMID_MODE_INHERENT;
            dec_len <= RST_LEN;
            dec_uses_acc <= 1'b0;
            branch_taken <= 1'b0;
            ds_addr <= RST_BYTE;
            ds_rd <= 1'b0;
            ds_wr <= 1'b0;
            ds_wdata <= RST_BYTE;
            rmw_done <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            modk <= next_modk;
            bitn <= next_bitn;
            op_q <= next_op_q;
            ptr_wait <= next_ptr_wait;
            op_ready <= next_op_ready;
            dec_valid <= next_dec_valid;
            dec_illegal <= next_dec_illegal;
            dec_class <= next_dec_class;
            dec_mode <= next_dec_mode;
            dec_len <= next_dec_len;
            dec_uses_acc <= next_dec_uses_acc;
            branch_taken <= next_branch_taken;
            ds_addr <= next_ds_addr;
            ds_rd <= next_ds_rd;
            ds_wr <= next_ds_wr;
            ds_wdata <= next_ds_wdata;
            rmw_done <= next_rmw_done;
        end
    end

    // Checks assume ce held high; a frozen cycle would stretch the sequences
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    property p_ptr_addr;
        start && needs_rmw && c_mode == AMID_MODE_INDIRECT |=> ds_rd &&
            ds_addr == (op_q[4] ? 8'h81 : 8'h80);
    endproperty
    a_ptr_addr: assert property (p_ptr_addr) else $error("wrong pointer address");

    property p_ptr_follow;
        state == AMID_ST_PTR && ptr_wait |=> ds_rd && ds_addr == $past(ds_rdata);
    endproperty
    a_ptr_follow: assert property (p_ptr_follow) else $error("pointer not followed");

    property p_ind_len;
        dec_valid && dec_mode == AMID_MODE_INDIRECT |-> dec_len == 2'h1;
    endproperty
    a_ind_len: assert property (p_ind_len) else $error("indirect length not one");

    property p_inh_len;
        dec_valid && dec_mode == AMID_MODE_INHERENT |-> dec_len == 2'h1;
    endproperty
    a_inh_len: assert property (p_inh_len) else $error("inherent length not one");

    property p_ext_noacc;
        dec_valid && dec_mode == AMID_MODE_EXT |-> !dec_uses_acc;
    endproperty
    a_ext_noacc: assert property (p_ext_noacc) else $error("goto or call uses a register");

    property p_wb_same;
        ds_rd && state == AMID_ST_READ |-> ##2 ds_wr && ds_addr == $past(ds_addr, 2);
    endproperty
    a_wb_same: assert property (p_wb_same) else $error("write-back address differs");

    property p_rmw_len;
        start && needs_rmw && c_mode != AMID_MODE_INDIRECT |-> ##4 rmw_done;
    endproperty
    a_rmw_len: assert property (p_rmw_len) else $error("rmw did not finish");

    // Indirect pays two more cycles: pointer read latency and the operand launch
    property p_rmw_ind;
        start && needs_rmw && c_mode == AMID_MODE_INDIRECT |-> ##6 rmw_done;
    endproperty
    a_rmw_ind: assert property (p_rmw_ind) else $error("indirect rmw did not finish");

    property p_branch;
        start && c_cls == AMID_CLS_BRANCH |=> branch_taken == $past(cond_ok);
    endproperty
    a_branch: assert property (p_branch) else $error("branch decision wrong");

    property p_busy;
        !op_ready |=> !dec_valid && !dec_illegal;
    endproperty
    a_busy: assert property (p_busy) else $error("decode during rmw");

    c_ind: cover property (start && needs_rmw && c_mode == AMID_MODE_INDIRECT);
    c_btest: cover property (rmw_done && $past(branch_taken, 1));
    c_taken: cover property (branch_taken && dec_class == AMID_CLS_BRANCH);
    c_illegal: cover property (dec_illegal);
endmodule

// ### tb/amid_mem_model.sv
`timescale 1ns/1ps
// Data-space partner: one-cycle read latency, no wait states
module amid_mem_model (
    input wire logic clk,
    input wire logic [7:0] ds_addr,
    input wire logic ds_rd,
    input wire logic ds_wr,
    input wire logic [7:0] ds_wdata,
    output logic [7:0] ds_rdata
);
    logic [7:0] mem [256];
    int n_wr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    // Known contents so an operand read never returns unknowns
    initial
    begin
        n_wr = 0;
        ds_rdata = 8'h5A;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'hA5;
    end
    // Pointer cells 80h/81h are plain memory here
    // Idle bus toggles so a late sample never looks like good data
    always @(posedge clk)
    begin
        ds_rdata <= ds_rd ? mem[ds_addr] : ~ds_rdata;
        if (ds_wr)
        begin
            mem[ds_addr] <= ds_wdata;
            n_wr <= n_wr + 1;
            wr_addr <= ds_addr;
            wr_data <= ds_wdata;
        end
    end
endmodule

// ### tb/addr_mode_instr_decode_tb.sv
`timescale 1ns/1ps
// Case-equality compare, so an unknown never counts as a match
`define CHK(nm, ex, gt) \
    begin \
        total_checks++; \
        if ((gt) !== (ex)) \
        begin \
            n_fail++; \
            $display("Error %s expected %0h seen %0h", nm, ex, gt); \
        end \
    end
module addr_mode_instr_decode_tb;
    import amid_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic op_valid = 1'b0;
    logic [7:0] op_byte = 8'h00;
    logic [7:0] op_arg = 8'h00;
    logic flag_carry = 1'b0;
    logic flag_zero = 1'b0;
    logic [7:0] ds_rdata;
    logic op_ready, dec_valid, dec_illegal, dec_uses_acc, branch_taken;
    logic ds_rd, ds_wr, rmw_done;
    amid_class_e dec_class;
    amid_mode_e dec_mode;
    logic [1:0] dec_len;
    logic [7:0] ds_addr, ds_wdata;
    int n_fail = 0;
    int total_checks = 0;
    int n_ok = 0;
    int cyc = 0;
    int unsigned seed = 29;
    int e_v, e_cls, e_mode, e_len, e_acc, e_lo, e_bt;

    amid_decoder i_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .op_valid(op_valid), .op_byte(op_byte),
        .op_arg(op_arg), .flag_carry(flag_carry), .flag_zero(flag_zero), .ds_rdata(ds_rdata),
        .op_ready(op_ready), .dec_valid(dec_valid), .dec_illegal(dec_illegal),
        .dec_class(dec_class), .dec_mode(dec_mode), .dec_len(dec_len),
        .dec_uses_acc(dec_uses_acc), .branch_taken(branch_taken), .ds_addr(ds_addr),
        .ds_rd(ds_rd), .ds_wr(ds_wr), .ds_wdata(ds_wdata), .rmw_done(rmw_done)
    );
    amid_mem_model i_mem (
        .clk(clk), .ds_addr(ds_addr), .ds_rd(ds_rd), .ds_wr(ds_wr),
        .ds_wdata(ds_wdata), .ds_rdata(ds_rdata)
    );

    always #5 clk = ~clk;

    // Hang guard: a full opcode sweep needs well under 2000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            summarize();
        end
    end

    task summarize();
        $display("Checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Reference decode of the opcode map; -1 marks a field left open
    task automatic model(input logic [7:0] op);
        e_v = 1;
        e_cls = -1;
        e_len = 1;
        e_acc = -1;
        e_lo = 0;
        e_bt = 0;
        if (!op[7])
        begin
            e_cls = AMID_CLS_BRANCH;
            e_mode = AMID_MODE_REL;
            e_bt = int'((op[6] ? flag_carry : flag_zero) == op[5]);
        end
        else if (op[7:5] == 3'b100)
        begin
            e_mode = AMID_MODE_EXT;
            e_cls = AMID_CLS_REGMEM;
            e_len = 2;
            e_acc = 0;
        end
        else if (op[7:5] == 3'b101 && !op[3])
        begin
            e_v = INH_VALID_MASK[{op[4], op[2:0]}];
            e_mode = AMID_MODE_INHERENT;
            e_cls = AMID_CLS_CONTROL;
        end
        else if (op[7:5] == 3'b101)
        begin
            e_mode = AMID_MODE_SHORT;
            e_cls = op[2] ? AMID_CLS_REGMEM : AMID_CLS_RMW;
            e_acc = op[2] ? 1 : -1;
            e_lo = op[2] ? 0 : 3;
        end
        else if (op[7:5] == 3'b110)
        begin
            e_cls = AMID_CLS_BITMAN;
            e_mode = op[4] ? AMID_MODE_BITSC : AMID_MODE_BITTB;
            e_len = op[4] ? 2 : 3;
            e_lo = 3;
        end
        else if (!op[3])
        begin
            e_mode = AMID_MODE_INDIRECT;
            e_cls = op[2:1] == 2'b11 ? AMID_CLS_RMW : AMID_CLS_REGMEM;
            e_lo = op[2:1] == 2'b11 ? 5 : 0;
            e_acc = op[2:1] == 2'b11 ? 0 : 1;
        end
        else
        begin
            e_mode = op[4] ? AMID_MODE_DIRECT : AMID_MODE_IMM;
            e_len = 2;
            e_v = !(op inside {8'hE9, 8'hEE, 8'hEF});
            e_lo = (op[4] && op[2:1] == 2'b11) ? 3 : 0;
            e_cls = op[2:1] == 2'b11 ? AMID_CLS_RMW : AMID_CLS_REGMEM;
            e_acc = op[2:1] == 2'b11 ? 0 : 1;
        end
    endtask

    // Offer one opcode back to back, check its decode, then follow the memory cycle
    task automatic run(input logic [7:0] op);
        logic [7:0] tgt;
        logic [7:0] old;
        logic [7:0] nw;
        int lo;
        int w0;
        int bt;
        lo = 0;
        bt = 0;
        op_byte = op;
        op_arg = 8'(rnd());
        flag_carry = 1'(rnd());
        flag_zero = 1'(rnd());
        for (int k = 0; k < 4; k++)
            i_mem.mem[8'h80 + k] = 8'(rnd());
        i_mem.mem[op_arg] = 8'(rnd());
        model(op);
        tgt = (op[7:5] == 3'b111 && !op[3]) ? i_mem.mem[{7'h40, op[4]}] :
            op[6] ? op_arg : {6'h20, op[1:0]};
        old = i_mem.mem[tgt];
        nw = old;
        if (op[7:4] == 4'hD)
            nw[op[2:0]] = op[3];
        else if (op[7:5] == 3'b101)
            nw = op[4] ? old - 8'h01 : old + 8'h01;
        else if (op[7:5] == 3'b111)
            nw = op[0] ? old - 8'h01 : old + 8'h01;
        w0 = i_mem.n_wr;
        op_valid = 1'b1;
        @(negedge clk);
        `CHK("dec_valid", e_v, dec_valid)
        `CHK("dec_illegal", !e_v, dec_illegal)
        n_ok += int'(dec_valid === 1'b1);
        if (e_v)
        begin
            `CHK("dec_mode", e_mode, dec_mode)
            `CHK("dec_len", e_len, dec_len)
            `CHK("branch_taken", e_bt, branch_taken)
            if (e_cls >= 0) `CHK("dec_class", e_cls, dec_class)
            if (e_acc >= 0) `CHK("dec_uses_acc", e_acc, dec_uses_acc)
        end
        // Held request is ignored while busy; count the busy cycles
        while (op_ready !== 1'b1 && lo < 12)
        begin
            if (ds_wr === 1'b1)
                bt = int'(branch_taken === 1'b1);
            lo++;
            @(negedge clk);
        end
        if (e_lo >= 0) `CHK("busy_cycles", e_lo, lo)
        if (e_lo > 0)
        begin
            `CHK("write_count", w0 + 1, i_mem.n_wr)
            `CHK("write_addr", tgt, i_mem.wr_addr)
            `CHK("write_data", nw, i_mem.wr_data)
            if (op[7:4] == 4'hC) `CHK("bit_branch", int'(old[op[2:0]] == op[3]), bt)
        end
    endtask

    // Reset, a frozen clock enable, then every opcode with random operands
    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        `CHK("op_ready", 1'b1, op_ready)
        `CHK("dec_len", RST_LEN, dec_len)
        `CHK("dec_class", AMID_CLS_CONTROL, dec_class)
        `CHK("dec_mode", AMID_MODE_INHERENT, dec_mode)
        `CHK("ds_addr", RST_BYTE, ds_addr)
        ce = 1'b0;
        op_byte = 8'h20;
        op_valid = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("frozen_decode", 1'b0, dec_valid)
        ce = 1'b1;
        for (int i = 0; i < 256; i++)
            run(8'(i));
        op_valid = 1'b0;
        `CHK("valid_opcodes", NUM_VALID_OPS, n_ok)
        summarize();
    end
endmodule
